// ==== src/pli_pkg.sv ====
// Package for the LED select and interrupt control block
package pli_pkg;
  // Register addresses on the management bus
  localparam logic [4:0] PLI_ADDR_LED = 5'h14;
  localparam logic [4:0] PLI_ADDR_TALLY = 5'h15;
  localparam logic [4:0] PLI_ADDR_IRQ_CTRL = 5'h16;
  localparam logic [4:0] PLI_ADDR_IRQ_FLAG = 5'h17;
  // Reset values
  localparam logic [15:0] PLI_LED_RESET = 16'h3FE9;
  localparam logic [15:0] PLI_TALLY_RESET = 16'h0000;
  localparam logic [15:0] PLI_IRQ_CTRL_RESET = 16'h0000;
  // Field positions
  localparam int PLI_SECOND_INDICATOR_LSB = 3;
  localparam int PLI_FIRST_INDICATOR_LSB = 0;
  localparam int PLI_OE_BIT = 15;
  localparam int PLI_ROC_BIT = 14;
  localparam int PLI_POL_BIT = 13;
  localparam int PLI_AUTO_BIT = 12;
  localparam int PLI_RESETUP_BIT = 11;
  localparam int PLI_NUM_EVENTS = 11;

  // LED mode codes
  typedef enum logic [2:0] {
    PLI_LED_LINK = 3'h0,
    PLI_LED_ACT = 3'h1,
    PLI_LED_TXD = 3'h2,
    PLI_LED_RXD = 3'h3,
    PLI_LED_NONE = 3'h4,
    PLI_LED_SPEED = 3'h5,
    PLI_LED_DUPLEX = 3'h6,
    PLI_LED_SPECIAL = 3'h7
  } pli_led_mode_e;

  // Line status feeding the indicators
  typedef struct packed {
    logic link;
    logic activity;
    logic tx_data;
    logic rx_data;
    logic speed_100;
    logic full_duplex;
  } pli_line_s;

  // Management register access strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pli_mgmt_s;

  // Whole block state
  typedef struct packed {
    logic [15:0] led_select_control;
    logic [15:0] rx_error_tally;
    logic [15:0] irq_control_enable;
    logic [PLI_NUM_EVENTS-1:0] flags;
    logic [15:0] rdata;
    logic first_indicator;
    logic second_indicator;
    logic irq_out;
    logic irq_oe;
  } pli_state_s;
endpackage : pli_pkg

// ==== src/pli_core.sv ====
// LED selection, receive error tally and interrupt conditioning
`timescale 1ns/1ps
// Summary of operation
// - Second indicator picks its source from mode bits 5:3; 111 forces off.
// - First indicator uses bits 2:0; 111 shows link state; default activity.
// - Sixteen-bit receive error tally, readable and writable by management.
// - Interrupt pin driven only when enabled; polarity bit picks active level.
// - With clear-on-read set, reading the flag register clears the flags whose condition is gone.
// - With auto-clear set, a flag drops when its condition goes away.
// - Write one clears a flag, unless its condition persists; set wins with or without re-setup.
// - Enables for deep sleep wake, deep sleep entry, negotiation complete.
// - Enables for jabber, rx error, page, fault, ack, link down/up, remote fault.
// - Sticky flags, cleared by writing one, record each of the eleven events.
module pli_core
  import pli_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Management register access
  input wire pli_mgmt_s i_mgmt,
  output logic [15:0] o_rdata,
  // Line status and events, already on this clock
  input wire pli_line_s i_line,
  input wire logic [PLI_NUM_EVENTS-1:0] i_event_cond,
  input wire logic i_rx_error,
  // Indicators
  output logic o_first_indicator,
  output logic o_second_indicator,
  // Interrupt pin
  output logic o_irq_out,
  output logic o_irq_oe
);
  pli_state_s st;
  pli_state_s next_st;

  // Pick an indicator level from a mode code
  function automatic logic led_pick(input logic [2:0] mode, input pli_line_s ln, input logic special);
    logic v;
    v = 1'b0;
    case (pli_led_mode_e'(mode))
      PLI_LED_LINK: v = ln.link;
      PLI_LED_ACT: v = ln.activity;
      PLI_LED_TXD: v = ln.tx_data;
      PLI_LED_RXD: v = ln.rx_data;
      PLI_LED_NONE: v = 1'b0;
      PLI_LED_SPEED: v = ln.speed_100;
      PLI_LED_DUPLEX: v = ln.full_duplex;
      PLI_LED_SPECIAL: v = special;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : led_pick

  // Decoded access strobes
  logic wr_led;
  logic wr_tally;
  logic wr_ctrl;
  logic wr_flag;
  logic rd_flag;

  // Interrupt pending, combinational
  logic pending;

  // Per-flag next values from the flag loop
  logic [PLI_NUM_EVENTS-1:0] next_flags;

  // Control fields pulled out of the control register
  logic ctl_oe;
  logic ctl_roc;
  logic ctl_pol;
  logic ctl_auto;
  logic ctl_resetup;
  logic [PLI_NUM_EVENTS-1:0] ctl_enables;

  // Write to the indicator select register
  assign wr_led = i_mgmt.wr && (i_mgmt.addr == PLI_ADDR_LED);

  // Write to the receive error tally
  assign wr_tally = i_mgmt.wr && (i_mgmt.addr == PLI_ADDR_TALLY);

  // Write to the interrupt control register
  assign wr_ctrl = i_mgmt.wr && (i_mgmt.addr == PLI_ADDR_IRQ_CTRL);

  // Write-one-to-clear on the flag register
  assign wr_flag = i_mgmt.wr && (i_mgmt.addr == PLI_ADDR_IRQ_FLAG);

  // Read of the flag register, for clear-on-read
  assign rd_flag = i_mgmt.rd && (i_mgmt.addr == PLI_ADDR_IRQ_FLAG);

  assign ctl_oe = st.irq_control_enable[PLI_OE_BIT];
  assign ctl_pol = st.irq_control_enable[PLI_POL_BIT];

  assign ctl_roc = st.irq_control_enable[PLI_ROC_BIT];

  assign ctl_auto = st.irq_control_enable[PLI_AUTO_BIT];

  assign ctl_resetup = st.irq_control_enable[PLI_RESETUP_BIT];

  assign ctl_enables = st.irq_control_enable[PLI_NUM_EVENTS-1:0];

  generate
    for (genvar g = 0; g < PLI_NUM_EVENTS; g++)
    begin : g_flag
      // Clears first, then the set, so the set wins
      always_comb
      begin
        next_flags[g] = st.flags[g];
        if (rd_flag && ctl_roc)
        begin
          next_flags[g] = 1'b0;
        end
        if (wr_flag && i_mgmt.wdata[g] && !(ctl_resetup && i_event_cond[g]))
        begin
          next_flags[g] = 1'b0;
        end
        if (ctl_auto && !i_event_cond[g])
        begin
          next_flags[g] = 1'b0;
        end
        // Condition level sets the flag
        if (i_event_cond[g])
        begin
          next_flags[g] = 1'b1;
        end
      end
    end
  endgenerate

  // Next state of the whole block
  always_comb
  begin
    next_st = st;
    pending = 1'b0;

    // Indicator select register write
    if (wr_led)
    begin
      next_st.led_select_control = i_mgmt.wdata;
    end

    // Interrupt control register write
    if (wr_ctrl)
    begin
      next_st.irq_control_enable = i_mgmt.wdata;
    end

    if (wr_tally)
    begin
      next_st.rx_error_tally = i_mgmt.wdata;
    end
    else if (i_rx_error && (st.rx_error_tally != 16'hFFFF))
    begin
      // Saturates rather than wrapping to zero
      next_st.rx_error_tally = st.rx_error_tally + 16'h0001;
    end

    next_st.flags = next_flags;

    pending = |(st.flags & ctl_enables);

    next_st.irq_oe = ctl_oe;
    next_st.irq_out = ctl_pol ? pending : !pending;

    next_st.second_indicator = led_pick(st.led_select_control[PLI_SECOND_INDICATOR_LSB +: 3], i_line, 1'b0);

    next_st.first_indicator = led_pick(st.led_select_control[PLI_FIRST_INDICATOR_LSB +: 3], i_line, i_line.link);

    // Read data for the addressed register
    case (i_mgmt.addr)
      PLI_ADDR_LED: next_st.rdata = st.led_select_control;
      PLI_ADDR_TALLY: next_st.rdata = st.rx_error_tally;
      PLI_ADDR_IRQ_CTRL: next_st.rdata = st.irq_control_enable;
      // Upper flag bits read as zero
      PLI_ADDR_IRQ_FLAG: next_st.rdata = {5'h00, st.flags};
      default: next_st.rdata = 16'h0000;
    endcase
  end

  // State register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      // Everything not listed below resets to zero
      st <= '0;
      st.led_select_control <= PLI_LED_RESET;
      st.rx_error_tally <= PLI_TALLY_RESET;
      st.irq_control_enable <= PLI_IRQ_CTRL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Read data straight from its flop
  assign o_rdata = st.rdata;

  // Indicators straight from their flops
  assign o_first_indicator = st.first_indicator;
  assign o_second_indicator = st.second_indicator;

  // Interrupt pin straight from its flops
  assign o_irq_out = st.irq_out;
  assign o_irq_oe = st.irq_oe;
endmodule : pli_core

// ==== verification/pli_core_chk.sv ====
// Assertions on the control block ports
`timescale 1ns/1ps
module pli_core_chk
  import pli_pkg::*;
(
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire pli_mgmt_s i_mgmt,
  input wire logic [15:0] o_rdata,
  input wire pli_line_s i_line,
  input wire logic [PLI_NUM_EVENTS-1:0] i_event_cond,
  input wire logic i_rx_error,
  input wire logic o_first_indicator,
  input wire logic o_second_indicator,
  input wire logic o_irq_out,
  input wire logic o_irq_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Write strobes for registers 14h and 16h, and a quiet tally read with no rx error
  wire logic w14 = i_mgmt.wr && i_mgmt.addr == 5'h14;
  wire logic w16 = i_mgmt.wr && i_mgmt.addr == 5'h16;
  wire logic t15 = i_mgmt.addr == 5'h15 && !i_mgmt.wr && !i_rx_error;
  property p_l1; w14 && i_mgmt.wdata[5:3] == 3'h7 ##1 !w14 |=> !o_second_indicator; endproperty
  a_l1: assert property (p_l1) else $error("second_indicator on");
  property p_l0; w14 && i_mgmt.wdata[2:0] == 3'h7 ##1 !w14 |=> o_first_indicator == $past(i_line.link); endproperty
  a_l0: assert property (p_l0) else $error("first_indicator link");
  property p_um; !(i_mgmt.addr inside {[5'h14:5'h17]}) |=> o_rdata == 16'h0000; endproperty
  a_um: assert property (p_um) else $error("unmapped");
  property p_tl; t15 ##1 t15 |=> $stable(o_rdata); endproperty
  a_tl: assert property (p_tl) else $error("tally moved");
  property p_ft; i_mgmt.addr == 5'h17 |=> o_rdata[15:11] == 5'h00; endproperty
  a_ft: assert property (p_ft) else $error("flag top");
  property p_oe; w16 && !i_mgmt.wdata[15] |-> ##[1:2] !o_irq_oe; endproperty
  a_oe: assert property (p_oe) else $error("oe on");
  property p_lo; w16 && i_mgmt.wdata == 16'h8001 ##1 (!i_mgmt.wr) [*2] ##0 i_event_cond[0] |=> ##1 !o_irq_out; endproperty
  a_lo: assert property (p_lo) else $error("irq low");
  property p_dr; o_irq_oe |-> $past(i_mgmt.wr, 2) || $past(o_irq_oe); endproperty
  a_dr: assert property (p_dr) else $error("oe rose");
  // Main scenarios
  c_w: cover property (w16);
  c_i: cover property (o_irq_oe && !o_irq_out);
  c_l: cover property (w14);
endmodule : pli_core_chk

// ==== verification/pli_sta.sv ====
// Management station model driving the register strobes
`timescale 1ns/1ps
module pli_sta
  import pli_pkg::*;
(
  // Clock and strobes
  input wire logic i_mclk,
  output pli_mgmt_s o_mgmt
);
  initial o_mgmt = '0;
  // One access held n cycles, then idle
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, input int n);
  begin
    o_mgmt <= '{wr: w, rd: !w, addr: a, wdata: d};
    repeat (n) @(posedge i_mclk);
    o_mgmt <= '0;
  end
  endtask : xfer
endmodule : pli_sta

// ==== verification/phy_led_irq_control_tb.sv ====
// Self-checking bench for the control block
`timescale 1ns/1ps
module phy_led_irq_control_tb import pli_pkg::*;;
  logic i_mclk = 0;
  logic i_rst = 1;
  logic rxe = 0;
  pli_mgmt_s mg;
  pli_line_s ln = 6'h20;
  logic [10:0] cd = '0;
  logic [15:0] rdat;
  logic i0, i1, irq, oe;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  pli_sta pli_sta_inst (.i_mclk(i_mclk), .o_mgmt(mg));
  pli_core pli_core_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_mgmt(mg), .o_rdata(rdat), .i_line(ln),
    .i_event_cond(cd), .i_rx_error(rxe), .o_first_indicator(i0), .o_second_indicator(i1),
    .o_irq_out(irq), .o_irq_oe(oe));
  initial forever #5 i_mclk = ~i_mclk;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
  begin
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
  begin
    pli_sta_inst.xfer(1'b1, a, d, 1);
    @(posedge i_mclk);
  end
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input int n);
  begin
    pli_sta_inst.xfer(1'b0, a, 16'h0000, n);
    #1 chk("rdata", rdat, e);
    @(posedge i_mclk);
  end
  endtask : rd
  task automatic ev(input logic [10:0] c);
  begin
    cd <= c;
    @(posedge i_mclk);
    cd <= '0;
    repeat (2) @(posedge i_mclk);
  end
  endtask : ev
  task automatic close_out;
  begin
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : close_out
  // Run the scenarios
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_rst <= 0;
    @(posedge i_mclk);
    rd(5'h14, 16'h3FE9, 1);
    rd(5'h16, 16'h0000, 1);
    rd(5'h10, 16'h0000, 1);
    wr(5'h14, 16'h003F);
    #1 chk("ind0", i0, 1);
    chk("ind1", i1, 0);
    wr(5'h15, 16'hFFFE);
    rxe <= 1;
    repeat (2) @(posedge i_mclk);
    rxe <= 0;
    rd(5'h15, 16'hFFFF, 2);
    wr(5'h16, 16'h8001);
    ev(11'h001);
    #1 chk("irq", {oe, irq}, 2'b10);
    rd(5'h17, 16'h0001, 1);
    wr(5'h17, 16'h0001);
    rd(5'h17, 16'h0000, 1);
    #1 chk("idle", irq, 1);
    @(posedge i_mclk);
    wr(5'h16, 16'hD001);
    ev(11'h001);
    rd(5'h17, 16'h0000, 1);
    wr(5'h16, 16'h4001);
    ev(11'h001);
    rd(5'h17, 16'h0001, 1);
    rd(5'h17, 16'h0000, 1);
    wr(5'h16, 16'hAC00);
    cd <= 11'h400;
    @(posedge i_mclk);
    wr(5'h17, 16'h0400);
    rd(5'h17, 16'h0400, 1);
    cd <= '0;
    #1 chk("pol", irq, 1);
    wr(5'h16, 16'h2800);
    #1 chk("oe", oe, 0);
    close_out;
  end
  // Cut a hang short
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      close_out;
    end
  end
endmodule : phy_led_irq_control_tb
bind pli_core pli_core_chk pli_core_chk_inst (.*);
